// File: verilog/btx_board_test.v
/*
 * Board test logic with two independent parity chains, one for the main
 * input/output section and one for the hardware monitor section.
 * Assumes all pin inputs are asynchronous to clk, that rst_n is the main
 * supply power-on reset, and that normal pin logic lies outside this block
 * and is switched by the mode outputs.
 */
//
// Contract
// - Frame and data bit low at release: enter
// - Either high at release: leave main test
// - Power-on reset clears main test mode
// - Host bus reset excluded from main chain
// - Main result drives serial transmit pin
// - All main signal pins feed chain one
// - Frame and data bit join chain later
// - Any single input flip inverts output
// - Main chain low when inputs low
// - After exit, inputs do not move pin
// - Monitor chain is separate and independent
// - Strap one at power-up enters monitor test
// - Mode lasts until strap zero at power-up
// - Monitor result drives shared monitor pin
// - Supply and analog pins excluded from chain
// - Voltage ID and SMBus pins; seed high
// - Normal functions off, pins inputs only
`timescale 1ns/1ps
`default_nettype none
`include "btx_consts.vh"

module btx_board_test #(
    parameter MAIN_WIDTH = `BTX_MAIN_WIDTH,
    parameter VID_WIDTH  = `BTX_MON_VID_WIDTH
) (
    input  wire                  clk,                       // 125 MHz clock.
    input  wire                  rst_n,                     // Power-on reset, low.
    input  wire                  host_reset_n,              // Host bus reset pin.
    input  wire                  frame_n,                   // Bus frame pin.
    input  wire                  lad0,                      // Bus data bit 0 pin.
    input  wire [MAIN_WIDTH-3:0] main_pins,                 // Other main pins.
    input  wire                  monitor_strap,             // Test select strap.
    input  wire [VID_WIDTH-1:0]  voltage_id,                // Voltage ID pins.
    input  wire                  smbus_clk,                 // SMBus clock pin.
    input  wire                  smbus_data,                // SMBus data pin.
    input  wire                  serial1_normal_tx,         // Normal transmit data.
    input  wire                  monitor_normal_out,        // Normal shared pin level.
    output reg                   serial1_transmit_out,      // Serial transmit pin.
    output reg                   monitor_shared_output_pin, // Shared monitor pin.
    output reg                   main_test_active,          // Main pins disconnected.
    output reg                   monitor_test_active        // Monitor pins disconnected.
);

    localparam MON_WIDTH = VID_WIDTH + 2;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    reg                  hrst_s1_reg;
    reg                  hrst_s2_reg;
    reg                  hrst_prev_reg;
    reg                  frame_s1_reg;
    reg                  frame_s2_reg;
    reg                  lad0_s1_reg;
    reg                  lad0_s2_reg;
    reg [MAIN_WIDTH-3:0] main_s1_reg;
    reg [MAIN_WIDTH-3:0] main_s2_reg;
    reg                  strap_s1_reg;
    reg                  strap_s2_reg;
    reg [MON_WIDTH-1:0]  mon_s1_reg;
    reg [MON_WIDTH-1:0]  mon_s2_reg;

    always @(posedge clk)
    begin
        hrst_s1_reg  <= host_reset_n;
        hrst_s2_reg  <= hrst_s1_reg;
        frame_s1_reg <= frame_n;
        frame_s2_reg <= frame_s1_reg;
        lad0_s1_reg  <= lad0;
        lad0_s2_reg  <= lad0_s1_reg;
        main_s1_reg  <= main_pins;
        main_s2_reg  <= main_s1_reg;
        strap_s1_reg <= monitor_strap;
        strap_s2_reg <= strap_s1_reg;
        mon_s1_reg   <= {voltage_id, smbus_clk, smbus_data};
        mon_s2_reg   <= mon_s1_reg;
    end

    // ------------------------------------------------------------------------
    // Main section mode
    // ------------------------------------------------------------------------
    reg  main_mode_reg;
    reg  main_mode_next;
    wire hrst_rise;

    assign hrst_rise = hrst_s2_reg & ~hrst_prev_reg;

    always @*
    begin
        main_mode_next = main_mode_reg;
        if (hrst_rise)
        begin
            main_mode_next = ~frame_s2_reg & ~lad0_s2_reg;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            main_mode_reg <= `BTX_MODE_RESET;
            hrst_prev_reg <= 1'h1;
        end
        else
        begin
            main_mode_reg <= main_mode_next;
            hrst_prev_reg <= hrst_s2_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Monitor section mode, strap caught at the first edge after power-up
    // ------------------------------------------------------------------------
    reg mon_mode_reg;
    reg mon_armed_reg;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            mon_armed_reg <= 1'h0;
            mon_mode_reg  <= `BTX_MODE_RESET;
        end
        else if (!mon_armed_reg)
        begin
            mon_armed_reg <= 1'h1;
            mon_mode_reg  <= strap_s2_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Chains
    // ------------------------------------------------------------------------
    wire main_result;
    wire mon_result;

    // The host bus reset never enters the vector.
    btx_parity_chain #(
        .WIDTH (MAIN_WIDTH),
        .SEED  (`BTX_MAIN_SEED)
    ) u_main_chain (
        .clk       (clk),
        .rst_n     (rst_n),
        .enable    (main_mode_reg),
        .chain_in  ({main_s2_reg, frame_s2_reg, lad0_s2_reg}),
        .chain_out (main_result)
    );

    // Separate inputs, seed and output.
    btx_parity_chain #(
        .WIDTH (MON_WIDTH),
        .SEED  (`BTX_MON_SEED)
    ) u_mon_chain (
        .clk       (clk),
        .rst_n     (rst_n),
        .enable    (mon_mode_reg),
        .chain_in  (mon_s2_reg),
        .chain_out (mon_result)
    );

    // ------------------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            serial1_transmit_out      <= 1'h1;
            monitor_shared_output_pin <= 1'h1;
            main_test_active          <= `BTX_MODE_RESET;
            monitor_test_active       <= `BTX_MODE_RESET;
        end
        else
        begin
            main_test_active    <= main_mode_reg;
            monitor_test_active <= mon_mode_reg;
            if (main_mode_reg)
            begin
                serial1_transmit_out <= main_result;
            end
            else
            begin
                serial1_transmit_out <= serial1_normal_tx;
            end
            if (mon_mode_reg)
            begin
                monitor_shared_output_pin <= mon_result;
            end
            else
            begin
                monitor_shared_output_pin <= monitor_normal_out;
            end
        end
    end

endmodule

`default_nettype wire

// File: verilog/btx_consts.vh
/*
 * Constants for the board test parity chains: widths, reset values and
 * the chain seeds.
 * Assumes inclusion by its bare name from the design files.
 */
`ifndef BTX_CONSTS_VH
`define BTX_CONSTS_VH

// ----------------------------------------------------------------------------
// Chain widths
// ----------------------------------------------------------------------------
`define BTX_MAIN_WIDTH     86
`define BTX_MON_WIDTH      7
`define BTX_MON_VID_WIDTH  5

// ----------------------------------------------------------------------------
// Seeds and reset values
// ----------------------------------------------------------------------------
`define BTX_MAIN_SEED      1'h0
`define BTX_MON_SEED       1'h1
`define BTX_MODE_RESET     1'h0
`define BTX_OUT_RESET      1'h0

`endif

// File: verilog/btx_parity_chain.v
/*
 * One parity chain: the result is the seed combined by exclusive-or with
 * every chain input, registered, and gated by the chain's mode.
 * Assumes its inputs are already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "btx_consts.vh"

module btx_parity_chain #(
    parameter       WIDTH = 8,
    parameter [0:0] SEED  = 1'h0
) (
    input  wire             clk,        // System clock.
    input  wire             rst_n,      // Synchronous reset, active low.
    input  wire             enable,     // Chain mode active.
    input  wire [WIDTH-1:0] chain_in,   // Synchronised chain inputs.
    output reg              chain_out   // Registered chain result.
);

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            chain_out <= `BTX_OUT_RESET;
        end
        else if (enable)
        begin
            chain_out <= SEED ^ (^chain_in);
        end
        else
        begin
            chain_out <= `BTX_OUT_RESET;
        end
    end

endmodule

`default_nettype wire

// File: sim/btx_board_test_assertions.sv
/* Checker for the board test block: mode latching and both chain results.
   Assumes one clock, a synchronous low reset and the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module btx_board_test_assertions #(
    parameter MAIN_WIDTH = 86,
    parameter VID_WIDTH  = 5
) (
    input wire logic                  clk, // Clock.
    input wire logic                  rst_n, // Reset.
    input wire logic                  host_reset_n, // Host reset.
    input wire logic                  frame_n, // Frame pin.
    input wire logic                  lad0, // Data bit.
    input wire logic [MAIN_WIDTH-3:0] main_pins, // Main pins.
    input wire logic                  monitor_strap, // Strap.
    input wire logic [VID_WIDTH-1:0]  voltage_id, // VID pins.
    input wire logic                  smbus_clk, // SMBus clock.
    input wire logic                  smbus_data, // SMBus data.
    input wire logic                  serial1_normal_tx, // Normal data.
    input wire logic                  serial1_transmit_out, // Chain one pin.
    input wire logic                  monitor_shared_output_pin, // Chain two pin.
    input wire logic                  main_test_active, // Main mode.
    input wire logic                  monitor_test_active // Monitor mode.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_tx_normal;
        !main_test_active && $past(!main_test_active) && $past(rst_n)
            |-> serial1_transmit_out == $past(serial1_normal_tx);
    endproperty
    a_tx_normal: assert property (p_tx_normal) else $error("tx not normal");
    property p_main_hold;
        !$stable(main_test_active) && $past(rst_n)
            |-> $past(host_reset_n, 4) && !$past(host_reset_n, 5);
    endproperty
    a_main_hold: assert property (p_main_hold) else $error("mode moved");
    property p_main_enter;
        $rose(main_test_active) && $past(rst_n) |-> !$past(frame_n, 4) && !$past(lad0, 4);
    endproperty
    a_main_enter: assert property (p_main_enter) else $error("bad entry");
    property p_main_leave;
        $fell(main_test_active) && $past(rst_n) |-> $past(frame_n, 4) || $past(lad0, 4);
    endproperty
    a_main_leave: assert property (p_main_leave) else $error("bad exit");
    property p_por_clear;
        disable iff (1'b0) !rst_n |=> !main_test_active && !monitor_test_active;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("mode kept");
    property p_main_chain;
        main_test_active && $past(main_test_active, 5) |-> serial1_transmit_out ==
            ^{$past(main_pins, 4), $past(frame_n, 4), $past(lad0, 4)};
    endproperty
    a_main_chain: assert property (p_main_chain) else $error("chain one");
    property p_mon_chain;
        monitor_test_active && $past(monitor_test_active, 5) |-> monitor_shared_output_pin ==
            !(^{$past(voltage_id, 4), $past(smbus_clk, 4), $past(smbus_data, 4)});
    endproperty
    a_mon_chain: assert property (p_mon_chain) else $error("chain two");
    property p_mon_hold;
        !$stable(monitor_test_active) && $past(rst_n)
            |-> !$past(rst_n, 3) && monitor_test_active == $past(monitor_strap, 4);
    endproperty
    a_mon_hold: assert property (p_mon_hold) else $error("monitor mode");
    c_enter: cover property ($rose(main_test_active));
    c_leave: cover property ($fell(main_test_active));
    c_mon: cover property ($rose(monitor_test_active));
endmodule
bind btx_board_test btx_board_test_assertions #(
    .MAIN_WIDTH(MAIN_WIDTH),
    .VID_WIDTH(VID_WIDTH)
) u_chk (.*);
`default_nettype wire

// File: sim/btx_test_rig.sv
/* Board tester model: drives every chain pin.
   Assumes the bench hands over wanted levels by non-blocking assignment. */
`timescale 1ns/1ps
`default_nettype none
module btx_test_rig (
    input  wire logic [94:0] want, // Wanted levels.
    input  wire logic        clk, // Clock.
    output var  logic [94:0] pins // Board levels.
);
    // Levels move one falling edge later and then stay put.
    always @(negedge clk)
    begin
        pins <= want;
    end
endmodule
`default_nettype wire

// File: sim/btx_board_test_tb_top.sv
/* Bench for the board test block: both modes, both chains, resets.
   Assumes the design, its checker and the tester model compile first. */
`timescale 1ns/1ps
`default_nettype none
module btx_board_test_tb_top;
    logic              clk, rst_n, serial1_normal_tx, monitor_normal_out;
    logic       [94:0] want;
    wire  logic [94:0] pins;
    wire  logic [83:0] main_pins;
    wire  logic [4:0]  voltage_id;
    wire  logic        host_reset_n, frame_n, lad0, monitor_strap, smbus_clk, smbus_data;
    wire  logic        serial1_transmit_out, monitor_shared_output_pin;
    wire  logic        main_test_active, monitor_test_active;
    int                n_fail, total_checks, cyc;
    assign {monitor_strap, host_reset_n, voltage_id, smbus_clk, smbus_data, frame_n, lad0,
            main_pins} = pins;
    btx_test_rig rig (.want(want), .clk(clk), .pins(pins));
    btx_board_test dut (.*);
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", s, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic power_up(input logic strap);
        rst_n    <= 1'h0;
        want[94] <= strap;
        tick(6);
        rst_n <= 1'h1;
        tick(3);
        chk("main mode", 1'h0, main_test_active);
        chk("monitor mode", strap, monitor_test_active);
    endtask
    task automatic hrst_pulse(input logic [1:0] fl);
        want[85:84] <= fl;
        want[93]    <= 1'h0;
        tick(4);
        want[93] <= 1'h1;
        tick(8);
    endtask
    // Sets inputs high from the top, then low from the bottom.
    task automatic walk(input int lo, input int hi);
        logic e;
        for (int v = 1; v >= 0; v--)
            for (int k = 0; k <= hi - lo + 1; k++)
            begin
                if (k > 0)
                    want[v ? hi - k + 1 : lo + k - 1] <= v[0];
                tick(7);
                e = (lo == 0) ? ^want[85:0] : ~^want[92:86];
                chk("chain", e, lo == 0 ? serial1_transmit_out : monitor_shared_output_pin);
            end
    endtask
    initial
    begin
        rst_n              = 1'h0;
        serial1_normal_tx  = 1'h0;
        monitor_normal_out = 1'h1;
        want               = {2'h1, 93'h0};
        power_up(1'h0);
        chk("tx normal", 1'h0, serial1_transmit_out);
        chk("monitor normal", 1'h1, monitor_shared_output_pin);
        hrst_pulse(2'h0);
        chk("entered", 1'h1, main_test_active);
        walk(0, 85);
        want[3]  <= 1'h1;
        want[93] <= 1'h0;
        tick(8);
        chk("host reset", 1'h1, serial1_transmit_out);
        hrst_pulse(2'h0);
        chk("held", 1'h1, main_test_active);
        for (int i = 1; i < 3; i++)
        begin
            hrst_pulse(2'h0);
            chk("entered", 1'h1, main_test_active);
            hrst_pulse(i[1:0]);
            chk("left", 1'h0, main_test_active);
        end
        want[0] <= 1'h1;
        tick(7);
        chk("after exit", 1'h0, serial1_transmit_out);
        serial1_normal_tx <= 1'h1;
        tick(2);
        chk("tx normal", 1'h1, serial1_transmit_out);
        serial1_normal_tx <= 1'h0;
        tick(2);
        hrst_pulse(2'h0);
        power_up(1'h1);
        walk(86, 92);
        chk("main apart", 1'h0, serial1_transmit_out);
        power_up(1'h0);
        chk("monitor normal", 1'h1, monitor_shared_output_pin);
        monitor_normal_out <= 1'h0;
        tick(2);
        chk("monitor normal", 1'h0, monitor_shared_output_pin);
        give_verdict();
    end
endmodule
`default_nettype wire
